/* logic/rfa_pkg.sv */
/*
 * constants and carriers for the receive frame accept control block.
 * assumes a 16-bit host register port at byte offset 0x174 and a frame
 * stream from the internal switch port with per-frame verdict flags at end of frame.
 */
package rfa_pkg;
    localparam logic [8:0]  CTRL_ONE_OFFSET  = 9'h174;
    localparam logic [15:0] CTRL_ONE_RESET   = 16'h0800;
    localparam logic [15:0] CTRL_ONE_MASK    = 16'hfff3;
    localparam int          FLUSH_BIT        = 15;
    localparam int          UDP_BIT          = 14;
    localparam int          TCP_BIT          = 13;
    localparam int          IP_BIT           = 12;
    localparam int          UNI_BIT          = 11;
    localparam int          PAUSE_BIT        = 10;
    localparam int          CRC_BIT          = 9;
    localparam int          MULTI_BIT        = 8;
    localparam int          RUN_BIT          = 0;
    localparam int          QADDR_W          = 8;
    localparam logic [7:0]  QADDR_LAST       = 8'hff;
    localparam int          PAUSE_QUANTA_W   = 16;
    // one pause quantum is 512 bit times; at 100 Mb/s that is 5120 ns
    localparam int          QUANTUM_NS       = 5120;
    localparam int          CLK_NS           = 40;
    localparam logic [7:0]  QUANTUM_CYCLES   = 8'(QUANTUM_NS / CLK_NS);

    typedef struct packed {
        logic       sof;
        logic       eof;
        logic [7:0] data;
    } rfa_beat_t;

    typedef struct packed {
        logic is_udp;
        logic udp_bad;
        logic is_tcp;
        logic tcp_bad;
        logic is_ip;
        logic ip_bad;
        logic crc_bad;
        logic is_unicast;
        logic uni_match;
        logic is_multicast;
        logic multi_match;
    } rfa_verdict_t;
endpackage

/* logic/rfa_queue_mem.sv */
/*
 * receive queue storage: single write port, registered read port.
 * assumes the controller sweeps every address to erase it on flush.
 */
`timescale 1ns/1ps
module rfa_queue_mem (
    input  wire logic                            core_clk,
    input  wire logic                            wr_en,
    input  wire logic [rfa_pkg::QADDR_W-1:0]     wr_addr,
    input  wire logic [8:0]                      wr_data,
    input  wire logic [rfa_pkg::QADDR_W-1:0]     rd_addr,
    output logic      [8:0]                      rd_data
);
    logic [8:0] mem [0:(1<<rfa_pkg::QADDR_W)-1];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule

/* logic/rfa_ctrl.sv */
/*
 * receive frame accept control: control register, frame admission,
 * queue write pointer, flush sweep and pause honouring.
 * assumes host strobes are synchronous to core_clk and the switch port
 * presents a verdict with each end-of-frame beat.
 */
`timescale 1ns/1ps
module rfa_ctrl (
    input  wire logic                         core_clk,
    input  wire logic                         nrst,
    input  wire logic [8:0]                   reg_addr,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    input  wire logic [15:0]                  reg_wdata,
    output logic      [15:0]                  reg_rdata,
    input  wire logic                         in_valid,
    input  wire rfa_pkg::rfa_beat_t           in_beat,
    input  wire rfa_pkg::rfa_verdict_t        in_verdict,
    input  wire logic                         full_duplex,
    input  wire logic                         pause_rx,
    input  wire logic [15:0]                  pause_quanta,
    input  wire logic [rfa_pkg::QADDR_W-1:0]  rd_addr,
    output logic      [8:0]                   rd_data,
    output logic      [rfa_pkg::QADDR_W-1:0]  wr_ptr,
    output logic      [rfa_pkg::QADDR_W-1:0]  commit_ptr,
    output logic                              frame_accepted,
    output logic                              frame_dropped,
    output logic                              tx_hold,
    output logic                              flushing
);
    logic [15:0]                  ctrl_one;
    logic                         in_frame;
    logic                         running;
    logic [rfa_pkg::QADDR_W-1:0]  sweep_addr;
    logic                         sweep_done;
    logic [rfa_pkg::QADDR_W-1:0]  mem_addr;
    logic [8:0]                   mem_data;
    logic                         mem_wr;
    logic [15:0]                  pause_left;
    logic [7:0]                   quantum_cnt;
    logic                         drop_now;
    logic                         store_beat;

    // verdict of a finished frame under the current enables
    function automatic logic frame_rejected(input logic [15:0] c,
                                            input rfa_pkg::rfa_verdict_t v);
        logic r;
        r = 1'b0;
        if (c[rfa_pkg::UDP_BIT] && v.is_udp && v.udp_bad) r = 1'b1;
        if (c[rfa_pkg::TCP_BIT] && v.is_tcp && v.tcp_bad) r = 1'b1;
        if (c[rfa_pkg::IP_BIT] && v.is_ip && v.ip_bad) r = 1'b1;
        if (!c[rfa_pkg::CRC_BIT] && v.crc_bad) r = 1'b1;
        if (v.is_unicast && !(c[rfa_pkg::UNI_BIT] && v.uni_match)) r = 1'b1;
        if (v.is_multicast && !(c[rfa_pkg::MULTI_BIT] && v.multi_match)) r = 1'b1;
        return r;
    endfunction

    wire flush_on = ctrl_one[rfa_pkg::FLUSH_BIT];
    wire hit      = reg_addr == rfa_pkg::CTRL_ONE_OFFSET;

    // control register, reserved bits 3..2 held at zero
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctrl_one <= rfa_pkg::CTRL_ONE_RESET;
        end else if (reg_wr && hit) begin
            ctrl_one <= reg_wdata & rfa_pkg::CTRL_ONE_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= hit ? ctrl_one : 16'h0000;
        end
    end

    // run state changes only between frames
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            running <= 1'b0;
        end else if (!in_frame && !(in_valid && in_beat.sof)) begin
            running <= ctrl_one[rfa_pkg::RUN_BIT] && !flush_on;
        end else if (!running && in_valid && in_beat.sof) begin
            running <= ctrl_one[rfa_pkg::RUN_BIT] && !flush_on;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            in_frame <= 1'b0;
        end else if (in_valid && in_beat.eof) begin
            in_frame <= 1'b0;
        end else if (in_valid && in_beat.sof) begin
            // only a frame whose first beat was stored counts as in progress
            in_frame <= store_beat;
        end
    end

    assign store_beat = in_valid && !flush_on && (in_frame ? running
                        : (in_beat.sof && ctrl_one[rfa_pkg::RUN_BIT]));
    assign drop_now   = store_beat && in_beat.eof && frame_rejected(ctrl_one, in_verdict);

    // write pointer rewinds to last commit on drop, to zero on flush
    always_ff @(posedge core_clk) begin
        if (!nrst || flush_on) begin
            wr_ptr     <= '0;
            commit_ptr <= '0;
        end else if (drop_now) begin
            wr_ptr <= commit_ptr;
        end else if (store_beat) begin
            wr_ptr <= wr_ptr + 1'b1;
            if (in_beat.eof) begin
                commit_ptr <= wr_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            frame_accepted <= 1'b0;
            frame_dropped  <= 1'b0;
        end else begin
            frame_accepted <= store_beat && in_beat.eof && !drop_now;
            frame_dropped  <= drop_now;
        end
    end

    // erase sweep across the whole queue once while flush is held
    always_ff @(posedge core_clk) begin
        if (!nrst || !flush_on) begin
            sweep_addr <= '0;
            flushing   <= 1'b0;
            sweep_done <= 1'b0;
        end else if (!sweep_done) begin
            sweep_addr <= sweep_addr + 1'b1;
            flushing   <= sweep_addr != rfa_pkg::QADDR_LAST;
            sweep_done <= sweep_addr == rfa_pkg::QADDR_LAST;
        end
    end

    assign mem_wr   = (flush_on && !sweep_done) || (store_beat && !drop_now);
    assign mem_addr = flush_on ? sweep_addr : wr_ptr;
    assign mem_data = flush_on ? 9'h000 : {in_beat.eof, in_beat.data};

    rfa_queue_mem u_mem (
        .core_clk (core_clk),
        .wr_en    (mem_wr),
        .wr_addr  (mem_addr),
        .wr_data  (mem_data),
        .rd_addr  (rd_addr),
        .rd_data  (rd_data)
    );

    // pause timer counted in quanta
    always_ff @(posedge core_clk) begin
        if (!nrst || !ctrl_one[rfa_pkg::PAUSE_BIT] || !full_duplex) begin
            pause_left  <= 16'h0000;
            quantum_cnt <= 8'h00;
        end else if (pause_rx) begin
            pause_left  <= pause_quanta;
            quantum_cnt <= 8'h00;
        end else if (pause_left != 16'h0000) begin
            if (quantum_cnt == rfa_pkg::QUANTUM_CYCLES - 8'h01) begin
                quantum_cnt <= 8'h00;
                pause_left  <= pause_left - 16'h0001;
            end else begin
                quantum_cnt <= quantum_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            tx_hold <= 1'b0;
        end else begin
            tx_hold <= ctrl_one[rfa_pkg::PAUSE_BIT] && full_duplex
                       && (pause_rx ? pause_quanta != 16'h0000
                                    : pause_left > 16'h0001
                                      || (pause_left == 16'h0001
                                          && quantum_cnt != rfa_pkg::QUANTUM_CYCLES - 8'h01));
        end
    end

    a_flush_rewinds: assert property (@(posedge core_clk) disable iff (!nrst)
        flush_on |=> wr_ptr == '0 && commit_ptr == '0)
        else $error("flush did not reset pointers");

    a_udp_drop: assert property (@(posedge core_clk) disable iff (!nrst)
        store_beat && in_beat.eof && ctrl_one[rfa_pkg::UDP_BIT] && in_verdict.is_udp
        && in_verdict.udp_bad |=> frame_dropped && !frame_accepted)
        else $error("bad udp frame kept");

    a_tcp_drop: assert property (@(posedge core_clk) disable iff (!nrst)
        store_beat && in_beat.eof && ctrl_one[rfa_pkg::TCP_BIT] && in_verdict.is_tcp
        && in_verdict.tcp_bad |=> frame_dropped)
        else $error("bad tcp frame kept");

    a_ip_drop: assert property (@(posedge core_clk) disable iff (!nrst)
        store_beat && in_beat.eof && ctrl_one[rfa_pkg::IP_BIT] && in_verdict.is_ip
        && in_verdict.ip_bad |=> frame_dropped)
        else $error("bad ip frame kept");

    a_crc_drop: assert property (@(posedge core_clk) disable iff (!nrst)
        store_beat && in_beat.eof && !ctrl_one[rfa_pkg::CRC_BIT] && in_verdict.crc_bad
        |=> frame_dropped && wr_ptr == $past(commit_ptr))
        else $error("crc error frame kept");

    a_uni_filter: assert property (@(posedge core_clk) disable iff (!nrst)
        store_beat && in_beat.eof && in_verdict.is_unicast && !ctrl_one[rfa_pkg::UNI_BIT]
        |=> frame_dropped)
        else $error("unicast passed with filter off");

    a_multi_filter: assert property (@(posedge core_clk) disable iff (!nrst)
        store_beat && in_beat.eof && in_verdict.is_multicast
        && !ctrl_one[rfa_pkg::MULTI_BIT] |=> frame_dropped)
        else $error("multicast passed with filter off");

    a_pause_gate: assert property (@(posedge core_clk) disable iff (!nrst)
        !full_duplex || !ctrl_one[rfa_pkg::PAUSE_BIT] |=> !tx_hold)
        else $error("pause honoured while disabled");

    a_run_frame: assert property (@(posedge core_clk) disable iff (!nrst)
        in_frame && running && !flush_on |=> running || !$past(in_frame))
        else $error("receive stopped mid frame");
endmodule

/* test/rfa_port_model.sv */
/* switch port model: sends one whole frame with its verdict on request.
   assumes the bench calls send from one process at a time. */
`timescale 1ns/1ps
module rfa_port_model (
    input  wire logic             core_clk,
    output logic                  in_valid,
    output rfa_pkg::rfa_beat_t    in_beat,
    output rfa_pkg::rfa_verdict_t in_verdict
);
    initial begin
        in_valid = 1'b0;
        in_beat = '0;
        in_verdict = '0;
    end
    task automatic send(input logic [7:0] len, input rfa_pkg::rfa_verdict_t v);
        for (int i = 0; i < len; i++) begin
            @(negedge core_clk);
            in_valid = 1'b1;
            in_beat = {i == 0, i == len - 1, 8'(i * 37)};
            in_verdict = v;
        end
        @(negedge core_clk);
        // released lines show no stale value
        in_valid = 1'b0;
        in_beat = ~in_beat;
        in_verdict = ~v;
    endtask
endmodule

/* test/rfa_ctrl_tb.sv */
/* self-checking bench for the receive frame accept control.
   assumes the switch port model in rfa_port_model drives the frame stream. */
`timescale 1ns/1ps
module rfa_ctrl_tb;
    logic                  core_clk = 1'b0;
    logic                  nrst = 1'b0;
    logic [8:0]            reg_addr = '0;
    logic                  reg_wr = 1'b0;
    logic                  reg_rd = 1'b0;
    logic [15:0]           reg_wdata = '0;
    logic [15:0]           reg_rdata;
    logic                  in_valid;
    rfa_pkg::rfa_beat_t    in_beat;
    rfa_pkg::rfa_verdict_t in_verdict;
    logic                  full_duplex = 1'b0;
    logic                  pause_rx = 1'b0;
    logic [15:0]           pause_quanta = '0;
    logic [7:0]            rd_addr = '0;
    logic [8:0]            rd_data;
    logic [7:0]            wr_ptr;
    logic [7:0]            commit_ptr;
    logic                  frame_accepted;
    logic                  frame_dropped;
    logic                  tx_hold;
    logic                  flushing;
    int                    fails = 0;
    int                    checks_done = 0;
    logic [31:0]           st = 32'd6185;
    logic [31:0]           r;
    logic [15:0]           got;
    logic [7:0]            p;
    logic [7:0]            len;
    logic                  e;

    rfa_ctrl rfa_ctrl_inst (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .in_valid(in_valid), .in_beat(in_beat), .in_verdict(in_verdict),
        .full_duplex(full_duplex), .pause_rx(pause_rx), .pause_quanta(pause_quanta),
        .rd_addr(rd_addr), .rd_data(rd_data), .wr_ptr(wr_ptr), .commit_ptr(commit_ptr),
        .frame_accepted(frame_accepted), .frame_dropped(frame_dropped),
        .tx_hold(tx_hold), .flushing(flushing));
    rfa_port_model rfa_port_model_inst (.core_clk(core_clk), .in_valid(in_valid),
        .in_beat(in_beat), .in_verdict(in_verdict));

    always #20 core_clk = ~core_clk;

    function automatic logic [31:0] rnd();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st;
    endfunction
    function automatic logic ok(input logic [15:0] c, input rfa_pkg::rfa_verdict_t v);
        return !(v.is_udp & v.udp_bad & c[14]) && !(v.is_tcp & v.tcp_bad & c[13])
            && !(v.is_ip & v.ip_bad & c[12]) && !(v.crc_bad & !c[9])
            && !(v.is_unicast & !(c[11] & v.uni_match))
            && !(v.is_multicast & !(c[8] & v.multi_match));
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        checks_done++;
        if (g !== x) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    task automatic frame(input logic [15:0] c, input logic [7:0] n, input logic [10:0] v);
        p = commit_ptr;
        e = ok(c, v);
        rfa_port_model_inst.send(n, v);
        chk({14'h0, frame_accepted, frame_dropped}, {14'h0, e, !e});
        chk({commit_ptr, wr_ptr}, e ? {2{8'(p + n)}} : {p, p});
    endtask
    task results;
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #(40 * 10000);
        fails++;
        results();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        @(negedge core_clk) nrst = 1'b1;
        rd(9'h174, got);
        chk(got, 16'h0800);
        wr(9'h174, 16'h7fff);
        wr(9'h176, 16'hffff);
        rd(9'h174, got);
        chk(got, 16'h7ff3);
        rd(9'h176, got);
        chk(got, 16'h0000);
        frame(16'h7ff3, 8'd1, 11'h040);
        rd_addr = 8'h00;
        @(negedge core_clk);
        chk({7'h0, rd_data}, 16'h0100);
        for (int k = 0; k < 24; k++) begin
            r = rnd();
            wr(9'h174, {1'b0, r[30:24], 7'h0, 1'b1});
            len = 8'(1 + r[19:16]);
            frame({1'b0, r[30:24], 8'h1}, len, r[10:0]);
        end
        wr(9'h174, 16'h0001);
        fork
            frame(16'h0001, 8'd6, 11'h0);
            begin
                repeat (2) @(negedge core_clk);
                wr(9'h174, 16'h0000);
            end
        join
        p = commit_ptr;
        rfa_port_model_inst.send(8'd4, '0);
        chk({7'h0, frame_accepted, commit_ptr}, {7'h0, 1'b0, p});
        wr(9'h174, 16'h8000);
        @(negedge core_clk);
        chk({15'h0, flushing}, 16'h1);
        repeat (260) @(negedge core_clk);
        rd_addr = 8'(rnd());
        @(negedge core_clk);
        chk({7'h0, flushing, wr_ptr}, 16'h0);
        chk({8'h0, commit_ptr}, 16'h0);
        chk({7'h0, rd_data}, 16'h0);
        wr(9'h174, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            full_duplex = k[1];
            wr(9'h174, {5'h0, k[0], 10'h0});
            pause_quanta = 16'h1;
            pause_rx = 1'b1;
            @(negedge core_clk);
            pause_rx = 1'b0;
            @(negedge core_clk);
            chk({15'h0, tx_hold}, {15'h0, k[0] & k[1]});
            repeat (130) @(negedge core_clk);
            chk({15'h0, tx_hold}, 16'h0);
        end
        results();
    end
endmodule
